// ===== logic/occ_console.sv
// front-panel console control: modes, lockout, display register, views
`timescale 1ns/1ps
`include "occ_params.svh"

// What this block does
// - lockout key disables all or mode/reset buttons
// - mode toggle alternates step and run
// - run entry blinks run lamp until start
// - toggle while running halts after next fetch
// - halt instruction stops, run lamp blinks again
// - start in run mode begins at program counter
// - start in step mode executes one instruction
// - boot selector positions pick three loaders
// - boot button loads chosen bootstrap program
// - sixteen-bit display register drives sixteen lamps
// - entry switch sets its display bit only
// - clear button zeroes display bits, entry switches never do
// - memory show loads addressed word to display
// - memory write stores display into addressed word
// - five view buttons are mutually exclusive
// - status view read-only, key and shift bits
// - status view carries ALU and supervisor flags
// - stopped instruction view shows and writes back
// - stopped counter view shows and writes back
// - general view uses four-bit register code
// - code switches weighted 8 4 2 1, lamps lit
// - codes 3,4,5 are zeros, IR, ones
// - clear zeroes code, increment adds one
// - power-up: step, cleared, counter view selected
module occ_console
#(
    parameter int unsigned DebounceCycles = `OCC_DEBOUNCE_CYC
)
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // operator panel
    input occ_pkg::occ_buttons_s buttons,
    input wire logic lockoutKey,
    input wire logic lockoutAllJumper,
    input wire logic [1:0] bootSelect,
    // lamps
    output logic stepLamp,
    output logic runLamp,
    output logic [15:0] displayLamps,
    output logic [4:0] viewLamps,
    output logic [3:0] codeLamps,
    output logic [2:0] senseLamps,
    // processor control
    output logic cpuRunEnable,
    output logic cpuStepPulse,
    output logic cpuResetPulse,
    input wire logic cpuStopped,
    input wire logic haltExecuted,
    // processor registers
    input occ_pkg::occ_status_s status,
    input wire logic [15:0] irValue,
    input wire logic [15:0] pcValue,
    input wire logic [15:0] genValue,
    output logic [3:0] regCode,
    output logic regWrite,
    output occ_pkg::occ_target_e regTarget,
    output logic [15:0] regWrData,
    // memory at the program counter address
    output logic memReadReq,
    output logic memWriteReq,
    output logic [15:0] memWrData,
    input wire logic memReadAck,
    input wire logic [15:0] memReadData,
    // bootstrap loader
    output logic bootRequest,
    output logic [1:0] bootSource
);

    typedef struct packed {
        logic [15:0] tickCnt;
        logic [7:0] blinkCnt;
        logic blink;
        occ_pkg::occ_buttons_s btnNow;
        occ_pkg::occ_buttons_s press;
        occ_pkg::occ_run_e run;
        occ_pkg::occ_view_e view;
        logic [15:0] disp;
        logic [3:0] code;
        logic [2:0] sense;
        logic stepPulse;
        logic resetPulse;
        logic regWrite;
        occ_pkg::occ_target_e regTarget;
        logic [15:0] regWrData;
        logic memRd;
        logic memWr;
        logic [15:0] memWrData;
        logic boot;
        logic [1:0] bootSrc;
    } occ_state_s;

    localparam logic [15:0] TickLast = 16'(DebounceCycles - 1);

    occ_state_s state_r;
    occ_state_s state_nxt;

    logic stopped;
    logic tick;
    logic edit;
    logic writable;
    logic [15:0] editVal;
    logic [15:0] source;
    occ_pkg::occ_buttons_s enableMask;
    occ_pkg::occ_buttons_s p;

    ////////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        state_nxt = state_r;
        state_nxt.stepPulse = 1'b0;
        state_nxt.resetPulse = 1'b0;
        state_nxt.regWrite = 1'b0;
        state_nxt.memRd = 1'b0;
        state_nxt.memWr = 1'b0;
        state_nxt.boot = 1'b0;
        p = state_r.press;
        stopped = (state_r.run == occ_pkg::RUN_STEP) || (state_r.run == occ_pkg::RUN_IDLE);
        // lockout masks
        enableMask = '1;
        if (lockoutKey && lockoutAllJumper)
        begin
            enableMask = '0;
        end
        else if (lockoutKey)
        begin
            enableMask.modeToggle = 1'b0;
            enableMask.resetBtn = 1'b0;
        end
        // sampling tick, debounced press events and blink rate
        tick = state_r.tickCnt == TickLast;
        state_nxt.tickCnt = tick ? 16'h0000 : state_r.tickCnt + 16'h0001;
        state_nxt.press = '0;
        if (tick)
        begin
            state_nxt.btnNow = buttons;
            state_nxt.press = buttons & ~state_r.btnNow & enableMask;
            if (state_r.blinkCnt == `OCC_BLINK_TICKS - 8'd1)
            begin
                state_nxt.blinkCnt = 8'h00;
                state_nxt.blink = ~state_r.blink;
            end
            else
            begin
                state_nxt.blinkCnt = state_r.blinkCnt + 8'h01;
            end
        end
        // step and run control
        case (state_r.run)
            occ_pkg::RUN_STEP:
            begin
                if (p.modeToggle)
                begin
                    state_nxt.run = occ_pkg::RUN_IDLE;
                end
                else if (p.start && cpuStopped)
                begin
                    state_nxt.stepPulse = 1'b1;
                end
            end
            occ_pkg::RUN_IDLE:
            begin
                if (p.modeToggle)
                begin
                    state_nxt.run = occ_pkg::RUN_STEP;
                end
                else if (p.start)
                begin
                    state_nxt.run = occ_pkg::RUN_ACTIVE;
                end
            end
            occ_pkg::RUN_ACTIVE:
            begin
                if (p.modeToggle)
                begin
                    state_nxt.run = occ_pkg::RUN_STOPPING;
                end
                else if (haltExecuted)
                begin
                    state_nxt.run = occ_pkg::RUN_IDLE;
                end
            end
            occ_pkg::RUN_STOPPING:
            begin
                if (cpuStopped)
                begin
                    state_nxt.run = occ_pkg::RUN_STEP;
                end
            end
            default:
            begin
                state_nxt.run = occ_pkg::RUN_STEP;
            end
        endcase
        if (p.resetBtn)
        begin
            state_nxt.run = occ_pkg::RUN_STEP;
            state_nxt.resetPulse = 1'b1;
        end
        // bootstrap
        if (p.boot && stopped && bootSelect != `OCC_BOOT_NONE)
        begin
            state_nxt.boot = 1'b1;
            state_nxt.bootSrc = bootSelect;
        end
        // view select, register code and sense switches
        for (int i = 0; i < 5; i++)
        begin
            if (p.view[i])
            begin
                state_nxt.view = occ_pkg::occ_view_e'(3'(i));
            end
        end
        if (p.codeClear)
        begin
            state_nxt.code = `OCC_CODE_RESET;
        end
        else if (p.codeIncr)
        begin
            state_nxt.code = state_r.code + 4'h1;
        end
        else
        begin
            state_nxt.code = state_r.code ^ p.code;
        end
        state_nxt.sense = state_r.sense ^ p.sense;
        // display register
        edit = p.dispClear || (|p.entry);
        editVal = (p.dispClear ? 16'h0000 : state_r.disp) | p.entry;
        writable = 1'b1;
        source = genValue;
        state_nxt.regTarget = occ_pkg::TGT_GEN;
        case (state_r.view)
            occ_pkg::VIEW_IR:
            begin
                source = irValue;
                state_nxt.regTarget = occ_pkg::TGT_IR;
            end
            occ_pkg::VIEW_PC:
            begin
                source = pcValue;
                state_nxt.regTarget = occ_pkg::TGT_PC;
            end
            occ_pkg::VIEW_GEN:
            begin
                if (state_r.code == `OCC_CODE_ZEROS)
                begin
                    source = 16'h0000;
                    writable = 1'b0;
                end
                else if (state_r.code == `OCC_CODE_ONES)
                begin
                    source = 16'hffff;
                    writable = 1'b0;
                end
                else if (state_r.code == `OCC_CODE_IR)
                begin
                    source = irValue;
                    state_nxt.regTarget = occ_pkg::TGT_IR;
                end
            end
            default:
            begin
                writable = 1'b0;
            end
        endcase
        case (state_r.view)
            occ_pkg::VIEW_STATUS:
            begin
                state_nxt.disp = status;
            end
            occ_pkg::VIEW_MEM:
            begin
                if (edit)
                begin
                    state_nxt.disp = editVal;
                end
                if (p.memShow && stopped)
                begin
                    state_nxt.memRd = 1'b1;
                end
                if (p.memWrite && stopped)
                begin
                    state_nxt.memWr = 1'b1;
                    state_nxt.memWrData = state_r.disp;
                end
                if (memReadAck)
                begin
                    state_nxt.disp = memReadData;
                end
            end
            default:
            begin
                if (stopped && edit && writable)
                begin
                    state_nxt.disp = editVal;
                    state_nxt.regWrite = 1'b1;
                    state_nxt.regWrData = editVal;
                end
                else if (stopped && !state_r.regWrite)
                begin
                    state_nxt.disp = source;
                end
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_r <= '0;
            state_r.run <= occ_pkg::RUN_STEP;
            state_r.view <= occ_pkg::VIEW_PC;
            state_r.disp <= `OCC_DISP_RESET;
            state_r.code <= `OCC_CODE_RESET;
            state_r.sense <= `OCC_SENSE_RESET;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs

    assign stepLamp = state_r.run == occ_pkg::RUN_STEP;
    assign runLamp = (state_r.run == occ_pkg::RUN_IDLE) ? state_r.blink :
        (state_r.run == occ_pkg::RUN_ACTIVE || state_r.run == occ_pkg::RUN_STOPPING);
    assign displayLamps = state_r.disp;
    assign viewLamps = 5'h01 << state_r.view;
    assign codeLamps = state_r.code;
    assign senseLamps = state_r.sense;
    assign cpuRunEnable = state_r.run == occ_pkg::RUN_ACTIVE;
    assign cpuStepPulse = state_r.stepPulse;
    assign cpuResetPulse = state_r.resetPulse;
    assign regCode = state_r.code;
    assign regWrite = state_r.regWrite;
    assign regTarget = state_r.regTarget;
    assign regWrData = state_r.regWrData;
    assign memReadReq = state_r.memRd;
    assign memWriteReq = state_r.memWr;
    assign memWrData = state_r.memWrData;
    assign bootRequest = state_r.boot;
    assign bootSource = state_r.bootSrc;

endmodule

// ===== logic/occ_params.svh
// timing counts, reset values and select codes of the operator console
`ifndef OCC_PARAMS_SVH
`define OCC_PARAMS_SVH
`define OCC_CLK_MHZ 50
`define OCC_DEBOUNCE_US 1000
`define OCC_DEBOUNCE_CYC (`OCC_DEBOUNCE_US * `OCC_CLK_MHZ)
`define OCC_BLINK_TICKS 8'd250
`define OCC_DISP_RESET 16'h0000
`define OCC_CODE_RESET 4'h0
`define OCC_SENSE_RESET 3'h0
`define OCC_CODE_ZEROS 4'h3
`define OCC_CODE_IR 4'h4
`define OCC_CODE_ONES 4'h5
`define OCC_BOOT_NONE 2'h0
`define OCC_BOOT_TTY 2'h1
`define OCC_BOOT_FAST_TAPE 2'h2
`define OCC_BOOT_DISC 2'h3
`endif

// ===== logic/occ_pkg.sv
// types shared by the operator console logic
package occ_pkg;
    typedef enum logic [1:0] {RUN_STEP, RUN_IDLE, RUN_ACTIVE, RUN_STOPPING} occ_run_e;
    typedef enum logic [2:0] {VIEW_MEM, VIEW_STATUS, VIEW_IR, VIEW_PC, VIEW_GEN} occ_view_e;
    typedef enum logic [1:0] {TGT_IR, TGT_PC, TGT_GEN} occ_target_e;

    // one bit per pushbutton, high while held
    typedef struct packed {
        logic [15:0] entry;
        logic [3:0] code;
        logic [2:0] sense;
        logic [4:0] view;
        logic modeToggle;
        logic start;
        logic boot;
        logic memShow;
        logic memWrite;
        logic dispClear;
        logic codeClear;
        logic codeIncr;
        logic resetBtn;
    } occ_buttons_s;

    // processor status word, packed in display bit order 15..0
    typedef struct packed {
        logic [3:0] keyRegisterBits;
        logic aluCarryFlag;
        logic aluSignFlag;
        logic aluAllOnesFlag;
        logic aluOverflowFlag;
        logic [4:0] shiftCount;
        logic aluZeroFlag;
        logic supervisorModeFlag;
        logic unused;
    } occ_status_s;
endpackage

// ===== tb/occ_console_sva.sv
// concurrent checks on the console ports
`timescale 1ns/1ps
module occ_console_sva
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // lamps
    input wire logic stepLamp,
    input wire logic runLamp,
    input wire logic [15:0] displayLamps,
    input wire logic [4:0] viewLamps,
    input wire logic [3:0] codeLamps,
    // processor side
    input wire logic cpuRunEnable,
    input wire logic cpuStepPulse,
    input wire logic haltExecuted,
    input wire logic [3:0] regCode,
    input wire logic regWrite,
    input wire logic [15:0] regWrData,
    input wire logic memWriteReq,
    input wire logic [15:0] memWrData,
    input wire logic bootRequest,
    input wire logic [1:0] bootSource
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    reset_state_a: assert property ($rose(rst_b) |-> stepLamp && viewLamps == 5'h08
        && displayLamps == 16'h0000 && codeLamps == 4'h0) else $error("bad reset state");
    view_onehot_a: assert property ($onehot(viewLamps)) else $error("view not one-hot");
    step_exclusive_a: assert property (stepLamp |-> !runLamp && !cpuRunEnable)
        else $error("step lamp with run");
    run_steady_a: assert property (cpuRunEnable |-> runLamp) else $error("run lamp off");
    write_stopped_a: assert property ((regWrite || memWriteReq || bootRequest)
        |-> !cpuRunEnable) else $error("write while running");
    reg_data_a: assert property (regWrite |-> regWrData == displayLamps)
        else $error("write data differs from display");
    mem_data_a: assert property (memWriteReq |-> memWrData == displayLamps)
        else $error("memory data differs from display");
    boot_source_a: assert property (bootRequest |-> bootSource != 2'h0)
        else $error("boot without source");
    step_pulse_a: assert property (cpuStepPulse |-> stepLamp ##1 !cpuStepPulse)
        else $error("bad step pulse");
    code_lamps_a: assert property (codeLamps == regCode) else $error("code lamps differ");
    ones_code_a: assert property (viewLamps == 5'h10 && regCode == 4'h5 && stepLamp
        && !regWrite |=> displayLamps == 16'hffff) else $error("code five not all ones");
    halt_return_a: assert property (haltExecuted && cpuRunEnable
        |-> ##[1:3] !cpuRunEnable && !stepLamp) else $error("halt not honoured");
endmodule
bind occ_console occ_console_sva u_sva (.clock(clock), .rst_b(rst_b), .stepLamp(stepLamp),
    .runLamp(runLamp), .displayLamps(displayLamps), .viewLamps(viewLamps),
    .codeLamps(codeLamps), .cpuRunEnable(cpuRunEnable), .cpuStepPulse(cpuStepPulse),
    .haltExecuted(haltExecuted), .regCode(regCode), .regWrite(regWrite),
    .regWrData(regWrData), .memWriteReq(memWriteReq), .memWrData(memWrData),
    .bootRequest(bootRequest), .bootSource(bootSource));

// ===== tb/occ_cpu_model.sv
// processor, register file and memory model facing the console
`timescale 1ns/1ps
module occ_cpu_model
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // control
    input wire logic cpuRunEnable,
    input wire logic cpuStepPulse,
    output logic cpuStopped,
    // registers
    input wire logic [3:0] regCode,
    input wire logic regWrite,
    input occ_pkg::occ_target_e regTarget,
    input wire logic [15:0] regWrData,
    output logic [15:0] irValue,
    output logic [15:0] pcValue,
    output logic [15:0] genValue,
    // memory
    input wire logic memReadReq,
    input wire logic memWriteReq,
    input wire logic [15:0] memWrData,
    output logic memReadAck,
    output logic [15:0] memReadData
);
    logic [15:0] mem [0:15];
    logic [15:0] gen [0:15];
    logic [1:0] stopCnt;
    logic [1:0] rdCnt;
    int steps;
    assign cpuStopped = (stopCnt == 2'h3);
    assign genValue = (regCode == 4'h3) ? 16'h0000 : (regCode == 4'h5) ? 16'hffff :
        (regCode == 4'h4) ? irValue : gen[regCode];
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            stopCnt <= 2'h3;
            rdCnt <= 2'h0;
            memReadAck <= 1'b0;
            memReadData <= 16'h0000;
            irValue <= 16'h0000;
            pcValue <= 16'h0000;
            steps <= 0;
            for (int i = 0; i < 16; i++)
            begin
                mem[i] <= 16'h0000;
                gen[i] <= 16'h0000;
            end
        end
        else
        begin
            stopCnt <= cpuRunEnable ? 2'h0 : (cpuStopped ? stopCnt : stopCnt + 2'h1);
            if (regWrite)
            begin
                case (regTarget)
                    occ_pkg::TGT_IR: irValue <= regWrData;
                    occ_pkg::TGT_PC: pcValue <= regWrData;
                    default: gen[regCode] <= regWrData;
                endcase
            end
            if (memWriteReq)
                mem[pcValue[3:0]] <= memWrData;
            if (cpuStepPulse)
                steps <= steps + 1;
            rdCnt <= memReadReq ? 2'h2 : ((rdCnt != 2'h0) ? rdCnt - 2'h1 : 2'h0);
            memReadAck <= (rdCnt == 2'h1);
            memReadData <= (rdCnt == 2'h1) ? mem[pcValue[3:0]] : ~memReadData;
        end
    end
endmodule

// ===== tb/tb_top.sv
// self-checking bench for the operator console
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin bad_count++; \
    $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_top;
    logic clock, rst_b, lockoutKey, lockoutAllJumper, haltExecuted;
    logic [1:0] bootSelect;
    occ_pkg::occ_buttons_s btn, pb;
    logic stepLamp, runLamp, cpuRunEnable, cpuStepPulse, cpuStopped, regWrite;
    logic memReadReq, memWriteReq, memReadAck, bootRequest;
    logic [15:0] displayLamps, irValue, pcValue, genValue, regWrData, memWrData, memReadData;
    logic [4:0] viewLamps;
    logic [3:0] codeLamps, regCode;
    logic [2:0] senseLamps;
    logic [1:0] bootSource;
    occ_pkg::occ_target_e regTarget;
    int bad_count = 0;
    int num_checks = 0;
    logic cpuResetPulse;
    int resetCount = 0;
    int bootCount = 0;
    // count one-cycle pulses, each seen at exactly one edge
    always @(posedge clock)
    begin
        if (cpuResetPulse === 1'b1)
            resetCount++;
        if (bootRequest === 1'b1)
            bootCount++;
    end
    occ_console #(.DebounceCycles(4)) dut (.clock(clock), .rst_b(rst_b), .buttons(btn),
        .lockoutKey(lockoutKey), .lockoutAllJumper(lockoutAllJumper),
        .bootSelect(bootSelect), .stepLamp(stepLamp), .runLamp(runLamp),
        .displayLamps(displayLamps), .viewLamps(viewLamps), .codeLamps(codeLamps),
        .senseLamps(senseLamps), .cpuRunEnable(cpuRunEnable), .cpuStepPulse(cpuStepPulse),
        .cpuResetPulse(cpuResetPulse), .cpuStopped(cpuStopped), .haltExecuted(haltExecuted),
        .status(occ_pkg::occ_status_s'(16'hab5a)), .irValue(irValue), .pcValue(pcValue),
        .genValue(genValue), .regCode(regCode), .regWrite(regWrite), .regTarget(regTarget),
        .regWrData(regWrData), .memReadReq(memReadReq), .memWriteReq(memWriteReq),
        .memWrData(memWrData), .memReadAck(memReadAck), .memReadData(memReadData),
        .bootRequest(bootRequest), .bootSource(bootSource));
    occ_cpu_model cpu (.clock(clock), .rst_b(rst_b), .cpuRunEnable(cpuRunEnable),
        .cpuStepPulse(cpuStepPulse), .cpuStopped(cpuStopped), .regCode(regCode),
        .regWrite(regWrite), .regTarget(regTarget), .regWrData(regWrData),
        .irValue(irValue), .pcValue(pcValue), .genValue(genValue),
        .memReadReq(memReadReq), .memWriteReq(memWriteReq), .memWrData(memWrData),
        .memReadAck(memReadAck), .memReadData(memReadData));
    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // press pb for a few debounce ticks, release, let the action land
    task go();
        @(posedge clock) btn <= pb;
        repeat (8) @(posedge clock);
        btn <= '0;
        pb = '0;
        repeat (10) @(posedge clock);
    endtask
    task final_report();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task t_edit();
        pb.entry = 16'h8008; go();
        `CHK(displayLamps, 16'h8008)
        `CHK(pcValue, 16'h8008)
        pb.entry = 16'h0008; go();
        `CHK(displayLamps, 16'h8008)
        pb.dispClear = 1'b1; go();
        `CHK(displayLamps, 16'h0000)
        pb.view = 5'h04; go();
        pb.entry = 16'h1234; go();
        `CHK(irValue, 16'h1234)
        pb.view = 5'h08; go();
        $display("edit done");
    endtask
    task t_lock();
        lockoutKey <= 1'b1;
        pb.modeToggle = 1'b1; go();
        `CHK(stepLamp, 1'b1)
        pb.entry = 16'h0001; go();
        `CHK(displayLamps, 16'h0001)
        lockoutAllJumper <= 1'b1;
        pb.entry = 16'h0002; go();
        `CHK(displayLamps, 16'h0001)
        lockoutKey <= 1'b0;
        $display("lock done");
    endtask
    task t_run();
        pb.modeToggle = 1'b1; go();
        `CHK({stepLamp, cpuRunEnable}, 2'b00)
        pb.start = 1'b1; go();
        `CHK({cpuRunEnable, runLamp}, 2'b11)
        @(posedge clock) haltExecuted <= 1'b1;
        @(posedge clock) haltExecuted <= 1'b0;
        repeat (4) @(posedge clock);
        `CHK({cpuRunEnable, stepLamp}, 2'b00)
        pb.start = 1'b1; go();
        pb.modeToggle = 1'b1; go();
        `CHK({stepLamp, runLamp, cpuRunEnable}, 3'b100)
        pb.start = 1'b1; go();
        `CHK(cpu.steps, 1)
        $display("run done");
    endtask
    task t_misc();
        logic lampWas;
        pb.modeToggle = 1'b1; go();
        lampWas = runLamp;
        // blink half period is 250 ticks of 4 cycles
        repeat (1000) @(posedge clock);
        `CHK(runLamp, ~lampWas)
        pb.start = 1'b1; go();
        lockoutAllJumper <= 1'b0;
        lockoutKey <= 1'b1;
        pb.resetBtn = 1'b1; go();
        `CHK(resetCount, 0)
        `CHK(cpuRunEnable, 1'b1)
        lockoutKey <= 1'b0;
        pb.resetBtn = 1'b1; go();
        `CHK(resetCount, 1)
        `CHK({stepLamp, cpuRunEnable}, 2'b10)
        $display("misc done");
    endtask
    task t_views();
        for (int i = 0; i < 5; i++)
        begin
            pb.view = 5'h01 << i; go();
            `CHK(viewLamps, 5'h01 << i)
        end
        pb.view = 5'h02; go();
        `CHK(displayLamps, 16'hab5a)
        pb.entry = 16'h0001; go();
        `CHK(displayLamps, 16'hab5a)
        $display("views done");
    endtask
    task t_code();
        pb.view = 5'h10; go();
        pb.codeIncr = 1'b1; go();
        pb.codeIncr = 1'b1; go();
        `CHK(codeLamps, 4'h2)
        pb.codeClear = 1'b1; go();
        pb.code = 4'h5; go();
        `CHK(codeLamps, 4'h5)
        `CHK(displayLamps, 16'hffff)
        pb.code = 4'h6; go();
        pb.entry = 16'h0010; go();
        `CHK(displayLamps, 16'h0000)
        pb.codeClear = 1'b1; go();
        pb.entry = 16'h0042; go();
        `CHK(cpu.gen[0], 16'h0042)
        $display("code done");
    endtask
    task t_mem();
        pb.view = 5'h01; go();
        pb.dispClear = 1'b1; go();
        pb.entry = 16'h00c3; go();
        pb.memWrite = 1'b1; go();
        `CHK(cpu.mem[irValue[3:0] & 4'h0 | pcValue[3:0]], 16'h00c3)
        pb.dispClear = 1'b1; go();
        `CHK(displayLamps, 16'h0000)
        pb.memShow = 1'b1; go();
        `CHK(displayLamps, 16'h00c3)
        $display("mem done");
    endtask
    task t_boot();
        for (int i = 1; i < 4; i++)
        begin
            bootSelect <= i[1:0];
            pb.boot = 1'b1; go();
            `CHK(bootSource, i[1:0])
        end
        bootSelect <= 2'h0;
        pb.boot = 1'b1; go();
        `CHK(bootCount, 3)
        $display("boot done");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        rst_b = 1'b0;
        btn = '0;
        pb = '0;
        lockoutKey = 1'b0;
        lockoutAllJumper = 1'b0;
        haltExecuted = 1'b0;
        bootSelect = 2'h0;
        repeat (4) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        #1;
        `CHK({stepLamp, runLamp, viewLamps, codeLamps, senseLamps}, 14'h2400)
        `CHK(displayLamps, 16'h0000)
        t_edit();
        t_lock();
        t_run();
        t_misc();
        t_views();
        t_code();
        t_mem();
        t_boot();
        final_report();
    end
    initial
    begin
        #400000;
        bad_count++;
        final_report();
    end
endmodule
